// >>> rtl/cgt_map.vh
// Purpose: Offsets, fields, reset values and timing for the clock generator control block
// Assumes: Avalon-MM word addressing of byte registers, index times four
// Notes:   Constants only
// How it works
// (RQ1) Capacitor: 384 fixed plus trim units, 639
// (RQ2) Trim step about 0.195 percent, inverse
// (RQ3) Trim resets to 128, range centre
// (RQ4) Software trims against timer capture measurements
// (RQ5) Software keeps trim copy in memory
// (RQ6) Generator keeps running during wait mode
// (RQ7) Software slows clocks before wait for power
// (RQ8) Stop halts activity, output clocks held low
// (RQ9) Stop keeps all register values intact
// (RQ10) Slow option reduces amplifier drive strength
// (RQ11) Slow option sets monitor external expectation
// (RQ12) Slow option defaults to cleared state
// (RQ13) Five byte registers, documented control bits
// (RQ14) Reset values; divider and stage unaffected
// (RQ15) Monitor and source forced states apply continuously
// (RQ16) Generator off bits force related bits
// (RQ17) Unstable clocks block certain bit writes
// (RQ18) Numeric registers ignore writes when locked
// (RQ19) Multiplier or trim write clears internal stable
// (RQ20) Clock loss sets fail, forces selection
// (RQ21) Source select routes external or internal clock
// (RQ22) External stable after 4096 external cycles
// (RQ23) Fail cleared by read then zero write
// (RQ24) Internal clock base times multiplier, zero one
// (RQ25) Interlocks use current state, forces same cycle
`ifndef CGT_MAP_VH
`define CGT_MAP_VH
`define CGT_IDX_CTRL      8'h36
`define CGT_IDX_MULT      8'h37
`define CGT_IDX_TRIM      8'h38
`define CGT_IDX_DIV       8'h39
`define CGT_IDX_STAGE     8'h3A
`define CGT_B_IRQ_EN      7
`define CGT_B_FAIL        6
`define CGT_B_MON_ON      5
`define CGT_B_SRC_SEL     4
`define CGT_B_INT_ON      3
`define CGT_B_INT_STB     2
`define CGT_B_EXT_ON      1
`define CGT_B_EXT_STB     0
`define CGT_RST_CTRL      8'h08
`define CGT_RST_MULT      7'h15
`define CGT_RST_TRIM      8'h80
`define CGT_CAP_FIXED     10'h180
`define CGT_EXT_STB_CYC   4096
`define CGT_INT_STB_CYC   32
`endif

// >>> rtl/cgt_clock_ctrl.v
// Purpose: Register file and interlocks of an on-chip clock generator
// Assumes: Avalon-MM slave, byte address = register index * 4
// Notes:   Oscillators are analog and outside; their levels arrive as inputs
`timescale 1ns/100ps
`default_nettype none
`include "cgt_map.vh"
module cgt_clock_ctrl #(
  parameter EXT_STB_CYC = `CGT_EXT_STB_CYC,
  parameter INT_STB_CYC = `CGT_INT_STB_CYC
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        stop_mode,
  input  wire        slow_crystal_option,
  input  wire        internal_osc_clock,
  input  wire        external_osc_clock,
  input  wire        internal_clock_lost,
  input  wire        external_clock_lost,
  output reg         osc_output_clock,
  output reg         bus_clock_output,
  output reg         internal_gen_enable,
  output reg         external_gen_enable,
  output reg         amp_low_drive,
  output reg         monitor_slow_ext,
  output reg         monitor_enable,
  output reg         monitor_irq,
  output reg  [9:0]  capacitor_units,
  output reg  [6:0]  multiplier_eff,
  output reg  [3:0]  divider_eff,
  output reg  [7:0]  stage_out
);
  reg        irq_en_q, fail_q, mon_on_q, src_sel_q, int_on_q, int_stb_q, ext_on_q, ext_stb_q;
  reg [6:0]  mult_q;
  reg [7:0]  trim_q;
  reg [3:0]  div_q;
  reg [7:0]  stage_q;
  reg        fail_seen_q;
  reg        ack_q;
  reg [12:0] ext_cnt_q;
  reg [5:0]  int_cnt_q;
  reg        ext_meta_q;
  reg        ext_sync_q;
  reg        ext_prev_q;
  reg        bus_div_q;
  wire [7:0] idx = avs_address[9:2];
  wire       req = (avs_read | avs_write) & ~ack_q;
  // Writes land only at the edge that sees waitrequest low
  wire       wr = avs_write & ack_q;
  wire       rd = avs_read & req;
  wire [7:0] wd = avs_writedata[7:0];
  wire       wr_ctrl = wr & (idx == `CGT_IDX_CTRL);
  wire       num_lock = mon_on_q | fail_q;                                   // [RQ18]
  wire       wr_mult = wr & (idx == `CGT_IDX_MULT) & ~num_lock & ~irq_en_q; // [RQ18] [RQ19]
  wire       wr_trim = wr & (idx == `CGT_IDX_TRIM) & ~num_lock & ~irq_en_q; // [RQ18] [RQ19]
  wire       dco_lock = num_lock | int_on_q | ~src_sel_q | ~ext_on_q;        // [RQ18]
  wire       wr_div = wr & (idx == `CGT_IDX_DIV) & ~dco_lock;
  wire       wr_stg = wr & (idx == `CGT_IDX_STAGE) & ~dco_lock;
  wire       int_loss = mon_on_q & internal_clock_lost;                      // [RQ20]
  wire       ext_loss = mon_on_q & external_clock_lost;                      // [RQ20]
  wire       ext_edge = ext_sync_q & ~ext_prev_q;
  reg  [7:0] c;
  reg        n_ie, n_fail, n_mon, n_src, n_ion, n_istb, n_eon, n_estb;
  always @* begin
    c = {irq_en_q, fail_q, mon_on_q, src_sel_q, int_on_q, int_stb_q, ext_on_q, ext_stb_q};
    n_ie = irq_en_q;
    n_mon = mon_on_q;
    n_src = src_sel_q;
    n_ion = int_on_q;
    n_eon = ext_on_q;
    if (wr_ctrl) begin
      // Sets need both clocks stable, judged on current state
      n_ie  = wd[`CGT_B_IRQ_EN] & ((irq_en_q | (mon_on_q & int_stb_q & ext_stb_q)));   // [RQ17] [RQ25]
      n_mon = wd[`CGT_B_MON_ON] & ((mon_on_q | (int_stb_q & ext_stb_q)));               // [RQ17] [RQ25]
      if (wd[`CGT_B_SRC_SEL] & ~src_sel_q & ext_stb_q)
        n_src = 1'b1;                                                                    // [RQ17]
      if (~wd[`CGT_B_SRC_SEL] & src_sel_q & int_stb_q)
        n_src = 1'b0;                                                                    // [RQ17]
      n_ion = wd[`CGT_B_INT_ON];
      n_eon = wd[`CGT_B_EXT_ON];
    end
    // Set by event wins over the software clear
    n_fail = fail_q | int_loss | ext_loss;                                               // [RQ20]
    if (wr_ctrl & ~wd[`CGT_B_FAIL] & fail_seen_q & ~int_loss & ~ext_loss)
      n_fail = 1'b0;                                                                     // [RQ23]
    if (n_fail | n_mon) begin
      n_mon = 1'b1;                                                                      // [RQ15]
      n_ion = 1'b1;
      n_eon = 1'b1;
    end
    if (int_loss)
      n_src = 1'b1;                                                                      // [RQ20]
    if (ext_loss)
      n_src = 1'b0;                                                                      // [RQ20]
    if (~n_src)
      n_ion = 1'b1;                                                                      // [RQ15]
    else
      n_eon = 1'b1;                                                                      // [RQ15]
    if (~n_ion) begin
      n_src = 1'b1;                                                                      // [RQ16]
      n_eon = 1'b1;
    end
    if (~n_eon) begin
      n_src = 1'b0;                                                                      // [RQ16]
      n_ion = 1'b1;
    end
    if (~n_mon) begin
      n_ie = 1'b0;                                                                       // [RQ15]
      n_fail = 1'b0;
    end
    n_istb = int_stb_q | (int_cnt_q == INT_STB_CYC[5:0]);
    if (~n_ion | int_loss | wr_mult | wr_trim)
      n_istb = 1'b0;                                                                     // [RQ16] [RQ19] [RQ20]
    n_estb = ext_stb_q | (ext_cnt_q == EXT_STB_CYC[12:0]);                              // [RQ22]
    if (~n_eon | ext_loss)
      n_estb = 1'b0;                                                                     // [RQ16] [RQ20]
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      {irq_en_q, fail_q, mon_on_q, src_sel_q, int_on_q, int_stb_q, ext_on_q, ext_stb_q} <= `CGT_RST_CTRL; // [RQ14]
      mult_q          <= `CGT_RST_MULT;                                                  // [RQ14]
      trim_q          <= `CGT_RST_TRIM;                                                  // [RQ3]
      fail_seen_q     <= 1'b0;
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      ext_cnt_q       <= 13'h0000;
      int_cnt_q       <= 6'h00;
      ext_meta_q      <= 1'b0;
      ext_sync_q      <= 1'b0;
      ext_prev_q      <= 1'b0;
      bus_div_q       <= 1'b0;
      osc_output_clock <= 1'b0;
      bus_clock_output <= 1'b0;
    end else begin
      // One wait cycle, then a single-cycle acknowledge
      ack_q           <= req;
      avs_waitrequest <= ~req;
      if (rd) begin
        case (idx)                                                                       // [RQ13]
          `CGT_IDX_CTRL:  avs_readdata <= {24'h000000, c};
          `CGT_IDX_MULT:  avs_readdata <= {25'h0000000, mult_q};
          `CGT_IDX_TRIM:  avs_readdata <= {24'h000000, trim_q};
          `CGT_IDX_DIV:   avs_readdata <= {28'h0000000, div_q};
          `CGT_IDX_STAGE: avs_readdata <= {24'h000000, stage_q};
          default:        avs_readdata <= 32'h00000000;
        endcase
      end
      if (rd & (idx == `CGT_IDX_CTRL))
        fail_seen_q <= fail_q;                                                           // [RQ23]
      else if (wr_ctrl)
        fail_seen_q <= 1'b0;
      // Stop freezes the clock state; registers simply hold while the bus still answers
      if (!stop_mode) begin                                                              // [RQ8] [RQ9]
        {irq_en_q, fail_q, mon_on_q, src_sel_q, int_on_q, int_stb_q, ext_on_q, ext_stb_q} <=
          {n_ie, n_fail, n_mon, n_src, n_ion, n_istb, n_eon, n_estb};                   // [RQ25]
        if (wr_mult)
          mult_q <= wd[6:0];
        if (wr_trim)
          trim_q <= wd;                                                                  // [RQ2]
        // Edge detector reads only the second and third flops
        ext_meta_q <= external_osc_clock;
        ext_sync_q <= ext_meta_q;
        ext_prev_q <= ext_sync_q;
        // A lost clock restarts the start-up count
        if (~n_eon | ext_loss)
          ext_cnt_q <= 13'h0000;                                                         // [RQ20]
        else if (ext_edge & ~ext_stb_q)
          ext_cnt_q <= ext_cnt_q + 13'h0001;                                             // [RQ22]
        if (~n_ion | wr_mult | wr_trim | int_stb_q)
          int_cnt_q <= 6'h00;
        else
          int_cnt_q <= int_cnt_q + 6'h01;
        bus_div_q        <= ~bus_div_q;
        osc_output_clock <= src_sel_q ? external_osc_clock : internal_osc_clock;         // [RQ21]
        bus_clock_output <= bus_div_q;
      end else begin
        osc_output_clock <= 1'b0;                                                        // [RQ8]
        bus_clock_output <= 1'b0;
      end
    end
  end
  // Divider and stage are loop-owned state with no reset
  always @(posedge clock) begin
    if (wr_div & ~stop_mode)
      div_q <= wd[3:0];
    if (wr_stg & ~stop_mode)
      stage_q <= wd;
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      internal_gen_enable <= 1'b1;
      external_gen_enable <= 1'b0;
      amp_low_drive       <= 1'b0;                                                       // [RQ12]
      monitor_slow_ext    <= 1'b0;
      monitor_enable      <= 1'b0;
      monitor_irq         <= 1'b0;
      capacitor_units     <= `CGT_CAP_FIXED + 10'h080;
      multiplier_eff      <= 7'h15;
      divider_eff         <= 4'h0;
      stage_out           <= 8'h00;
    end else begin
      internal_gen_enable <= int_on_q & ~stop_mode;                                      // [RQ6] [RQ8]
      external_gen_enable <= ext_on_q & ~stop_mode;
      amp_low_drive       <= slow_crystal_option;                                        // [RQ10]
      monitor_slow_ext    <= slow_crystal_option;                                        // [RQ11]
      monitor_enable      <= mon_on_q & ~stop_mode;
      monitor_irq         <= irq_en_q & fail_q;                                          // [RQ6]
      capacitor_units     <= `CGT_CAP_FIXED + {2'b00, trim_q};                           // [RQ1]
      multiplier_eff      <= (mult_q == 7'h00) ? 7'h01 : mult_q;                         // [RQ24]
      divider_eff         <= (div_q > 4'h9) ? 4'h9 : div_q;
      stage_out           <= stage_q;
    end
  end
endmodule // cgt_clock_ctrl
`default_nettype wire

// >>> testbench/cgt_clock_ctrl_sva.sv
// Purpose: Port assertions for the clock generator control block
// Assumes: One clock, sync active-low reset
// Notes:   Bound into every cgt_clock_ctrl
`timescale 1ns/100ps
`default_nettype none
module cgt_clock_ctrl_sva (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        stop_mode,
  input wire logic        slow_crystal_option,
  input wire logic        osc_output_clock,
  input wire logic        bus_clock_output,
  input wire logic        internal_gen_enable,
  input wire logic        external_gen_enable,
  input wire logic        amp_low_drive,
  input wire logic        monitor_slow_ext,
  input wire logic        monitor_enable,
  input wire logic [9:0]  capacitor_units
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_seen; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_ack; s_seen |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_rdata; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data above byte");
  property p_cap; capacitor_units >= 10'h180 && capacitor_units <= 10'h27F; endproperty
  a_cap: assert property (p_cap) else $error("capacitor out of range");
  // Outputs are registered, so the low level shows one cycle after stop
  property p_stop; stop_mode |=> !osc_output_clock && !bus_clock_output; endproperty
  a_stop: assert property (p_stop) else $error("clock running in stop");
  property p_hold; stop_mode && $past(stop_mode) && $past(stop_mode, 2) |-> $stable(capacitor_units); endproperty
  a_hold: assert property (p_hold) else $error("trim changed in stop");
  property p_drive; !stop_mode && !$past(stop_mode) |-> amp_low_drive == $past(slow_crystal_option); endproperty
  a_drive: assert property (p_drive) else $error("drive strength wrong");
  property p_mslow; !stop_mode && !$past(stop_mode) |-> monitor_slow_ext == $past(slow_crystal_option); endproperty
  a_mslow: assert property (p_mslow) else $error("monitor range wrong");
  property p_mon; monitor_enable |-> internal_gen_enable && external_gen_enable; endproperty
  a_mon: assert property (p_mon) else $error("monitor without both generators");
endmodule // cgt_clock_ctrl_sva
bind cgt_clock_ctrl cgt_clock_ctrl_sva i_cgt_clock_ctrl_sva (
  .clock(clock), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .stop_mode(stop_mode),
  .slow_crystal_option(slow_crystal_option), .osc_output_clock(osc_output_clock),
  .bus_clock_output(bus_clock_output), .internal_gen_enable(internal_gen_enable),
  .external_gen_enable(external_gen_enable), .amp_low_drive(amp_low_drive),
  .monitor_slow_ext(monitor_slow_ext), .monitor_enable(monitor_enable), .capacitor_units(capacitor_units)
);
`default_nettype wire

// >>> testbench/tb_clock_gen_trim_and_interlocks.sv
// Purpose: Register and interlock tests of the clock generator control block
// Assumes: One wait cycle per access, external stable count cut to 8
// Notes:   Oscillator levels come from the cycle counter
`timescale 1ns/100ps
`default_nettype none
module tb_clock_gen_trim_and_interlocks;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, osc_output_clock, bus_clock_output, internal_gen_enable;
  logic        stop_mode = 1'b0, slow_crystal_option = 1'b0, ext_run = 1'b0;
  logic        internal_osc_clock = 1'b0, external_osc_clock = 1'b0;
  logic        internal_clock_lost = 1'b0, external_clock_lost = 1'b0;
  logic        int_d = 1'b0, ext_d = 1'b0;
  logic        external_gen_enable, amp_low_drive, monitor_slow_ext, monitor_enable, monitor_irq;
  logic [9:0]  capacitor_units;
  logic [6:0]  multiplier_eff;
  logic [3:0]  divider_eff;
  logic [7:0]  stage_out, rd;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  cgt_clock_ctrl #(.EXT_STB_CYC(8), .INT_STB_CYC(32)) i_cgt_clock_ctrl (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .slow_crystal_option(slow_crystal_option),
    .internal_osc_clock(internal_osc_clock), .external_osc_clock(external_osc_clock),
    .internal_clock_lost(internal_clock_lost), .external_clock_lost(external_clock_lost),
    .osc_output_clock(osc_output_clock), .bus_clock_output(bus_clock_output),
    .internal_gen_enable(internal_gen_enable), .external_gen_enable(external_gen_enable),
    .amp_low_drive(amp_low_drive), .monitor_slow_ext(monitor_slow_ext), .monitor_enable(monitor_enable),
    .monitor_irq(monitor_irq), .capacitor_units(capacitor_units), .multiplier_eff(multiplier_eff),
    .divider_eff(divider_eff), .stage_out(stage_out)
  );
  always #12.5 clock = ~clock;
  // Whole run is under a thousand cycles; the ceiling only catches a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    internal_osc_clock <= cyc[0];
    external_osc_clock <= ext_run & cyc[1];
    int_d <= internal_osc_clock;
    ext_d <= external_osc_clock;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic eq(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
    acc(1'b0, idx, 8'h00);
    eq({2'b0, rd & m}, {2'b0, exp & m});
  endtask
  task automatic loss(input logic ext);
    internal_clock_lost <= ~ext;
    external_clock_lost <= ext;
    @(posedge clock);
    internal_clock_lost <= 1'b0;
    external_clock_lost <= 1'b0;
  endtask
  // Output clock is one cycle behind its source
  task automatic route(input logic sel);
    logic b;
    @(posedge clock);
    b = bus_clock_output;
    repeat (4) begin
      @(posedge clock);
      eq({9'h000, osc_output_clock}, {9'h000, sel ? ext_d : int_d});
      eq({9'h000, bus_clock_output}, {9'h000, ~b});
      b = bus_clock_output;
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    chk(8'h36, 8'h08, 8'hFF);
    chk(8'h37, 8'h15, 8'hFF);
    chk(8'h38, 8'h80, 8'hFF);
    eq(capacitor_units, 10'h200);
    route(1'b0);
    chk(8'h50, 8'h00, 8'hFF);
    acc(1'b1, 8'h38, 8'h10);
    chk(8'h38, 8'h10, 8'hFF);
    eq(capacitor_units, 10'h190);
    repeat (40) @(posedge clock);
    chk(8'h36, 8'h0C, 8'hFF);
    acc(1'b1, 8'h37, 8'h00);
    chk(8'h36, 8'h08, 8'hFF);
    eq({3'b0, multiplier_eff}, 10'h001);
    repeat (40) @(posedge clock);
    acc(1'b1, 8'h36, 8'h1A);
    chk(8'h36, 8'h0E, 8'hFF);
    ext_run <= 1'b1;
    repeat (60) @(posedge clock);
    chk(8'h36, 8'h0F, 8'hFF);
    acc(1'b1, 8'h36, 8'h1A);
    chk(8'h36, 8'h1F, 8'hFF);
    route(1'b1);
    slow_crystal_option <= 1'b1;
    stop_mode <= 1'b1;
    repeat (10) @(posedge clock);
    stop_mode <= 1'b0;
    chk(8'h36, 8'h1F, 8'hFF);
    eq({8'h00, amp_low_drive, monitor_slow_ext}, 10'h003);
    slow_crystal_option <= 1'b0;
    acc(1'b1, 8'h36, 8'h13);
    chk(8'h36, 8'h13, 8'hFF);
    eq({8'h00, internal_gen_enable, external_gen_enable}, 10'h001);
    acc(1'b1, 8'h39, 8'h0C);
    chk(8'h39, 8'h0C, 8'hFF);
    eq({6'h0, divider_eff}, 10'h009);
    acc(1'b1, 8'h3A, 8'h5A);
    chk(8'h3A, 8'h5A, 8'hFF);
    eq({2'b00, stage_out}, 10'h05A);
    acc(1'b1, 8'h36, 8'h1B);
    acc(1'b1, 8'h39, 8'h02);
    chk(8'h39, 8'h0C, 8'hFF);
    repeat (40) @(posedge clock);
    acc(1'b1, 8'h36, 8'h3F);
    chk(8'h36, 8'h3F, 8'hFF);
    eq({9'h000, monitor_enable}, 10'h001);
    acc(1'b1, 8'h37, 8'h05);
    chk(8'h37, 8'h00, 8'hFF);
    loss(1'b0);
    chk(8'h36, 8'h70, 8'h70);
    acc(1'b1, 8'h36, 8'h3F);
    chk(8'h36, 8'h20, 8'h60);
    loss(1'b0);
    acc(1'b1, 8'h36, 8'h3F);
    chk(8'h36, 8'h40, 8'h40);
    repeat (40) @(posedge clock);
    acc(1'b1, 8'h36, 8'hFF);
    chk(8'h36, 8'hC0, 8'hC0);
    eq({9'h000, monitor_irq}, 10'h001);
    loss(1'b1);
    chk(8'h36, 8'hEE, 8'hFF);
    acc(1'b1, 8'h36, 8'h1F);
    chk(8'h36, 8'h0E, 8'hFF);
    eq({9'h000, monitor_irq}, 10'h000);
    tally_and_finish();
  end
endmodule // tb_clock_gen_trim_and_interlocks
`default_nettype wire
